//--- pkg/card_cycle_params.svh
// Timing counts and widths for the 16-bit card cycle generator.
`ifndef CARD_CYCLE_PARAMS_SVH
`define CARD_CYCLE_PARAMS_SVH

// Reference clock period that the counts were sized against, in ns.
`define PCLK_PERIOD_NS 30
// Address and data widths on the card side.
`define CARD_ADDR_W 26
`define CARD_DATA_W 16
// Width of every phase counter.
`define CNT_W 5

// Address setup counts, in clocks.
`define SETUP_IO 5'h03
`define SETUP_MEM_WS1_LO 5'h02
`define SETUP_MEM_WS1_HI 5'h04
// Extra setup clocks added before the strobe falls.
`define SETUP_EXTRA 5'h02

// Command-active counts for 8-bit cycles, in clocks.
`define CMD8_NO_WAIT 5'h13
`define CMD8_WAIT 5'h17
`define CMD8_ZERO_WAIT 5'h07

// Command-active counts for 16-bit I/O cycles, in clocks.
`define CMD16_IO_WS0 5'h07
`define CMD16_IO_WS1 5'h0B

// Command-active counts for 16-bit memory cycles, in clocks.
`define CMD16_MEM_WS00 5'h09
`define CMD16_MEM_WS01 5'h0D
`define CMD16_MEM_WS10 5'h11
`define CMD16_MEM_WS11 5'h17
`define CMD16_MEM_ZERO_WAIT 5'h05

// Address hold counts, in clocks.
`define HOLD_IO 5'h02
`define HOLD_MEM_WS1_LO 5'h02
`define HOLD_MEM_WS1_HI 5'h03
// Extra hold clocks added after the strobe rises.
`define HOLD_EXTRA 5'h01

// Chip enable patterns, active low: both bytes or the low byte only.
`define CE_WORD 2'h0
`define CE_BYTE 2'h2
`define CE_OFF 2'h3

`endif

//--- pkg/card_cycle_pkg.sv
// Types shared by the card cycle generator and its helpers.
package card_cycle_pkg;

    // Window settings that shape one card cycle.
    typedef struct packed {
        logic [1:0] timing_set_select;
        logic [1:0] wait_state_field;
        logic zero_wait_select;
    } win_cfg_t;

    // One card access request from the host side.
    typedef struct packed {
        logic is_mem;
        logic is_write;
        logic is_16bit;
        logic attr_space;
        logic [25:0] addr;
        logic [15:0] wdata;
    } card_req_t;

    // Clock counts for the three phases of a cycle.
    typedef struct packed {
        logic [4:0] setup;
        logic [4:0] cmd;
        logic [4:0] hold;
    } cycle_counts_t;

    // Phase of the cycle sequencer, one-hot.
    typedef enum logic [3:0] {
        ST_IDLE  = 4'h1,
        ST_SETUP = 4'h2,
        ST_CMD   = 4'h4,
        ST_HOLD  = 4'h8
    } cycle_state_t;

endpackage

//--- src/pin_sync.sv
// Two-flop synchroniser for card pins.
`timescale 1ns/1ns
module pin_sync #(
    parameter int W = 1,
    parameter logic [W-1:0] INIT = '0
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic [W-1:0] d,
    output logic [W-1:0] q
);
    // First stage; only the second stage reads it.
    logic [W-1:0] meta_q;

    // Both stages take the idle level at reset.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            meta_q <= INIT;
            q <= INIT;
        end else begin
            meta_q <= d;
            q <= meta_q;
        end
    end
endmodule

//--- src/card_timing_table.sv
// Lookup of setup, command and hold counts from window settings.
`timescale 1ns/1ns
`include "card_cycle_params.svh"
module card_timing_table
    import card_cycle_pkg::*;
(
    input win_cfg_t cfg,
    input wire logic is_mem,
    input wire logic is_16bit,
    output cycle_counts_t counts
);
    // Picks the memory or I/O value, memory by the upper wait bit.
    function automatic logic [4:0] by_upper(input logic mem, input logic ws1,
                                            input logic [4:0] io_v,
                                            input logic [4:0] lo_v,
                                            input logic [4:0] hi_v);
        if (!mem) begin
            by_upper = io_v;
        end else begin
            by_upper = ws1 ? hi_v : lo_v;
        end
    endfunction

    // Only one timing set exists; every select value uses it.
    always_comb begin
        counts.setup = by_upper(is_mem, cfg.wait_state_field[1], `SETUP_IO,
                                `SETUP_MEM_WS1_LO, `SETUP_MEM_WS1_HI);
        counts.hold = by_upper(is_mem, cfg.wait_state_field[1], `HOLD_IO,
                               `HOLD_MEM_WS1_LO, `HOLD_MEM_WS1_HI);
        if (!is_16bit) begin
            // Byte cycles: I/O uses the low wait bit, memory any nonzero code.
            if ((is_mem ? (cfg.wait_state_field != 2'h0) : cfg.wait_state_field[0])) begin
                counts.cmd = `CMD8_WAIT;
            end else if (cfg.zero_wait_select) begin
                counts.cmd = `CMD8_ZERO_WAIT;
            end else begin
                counts.cmd = `CMD8_NO_WAIT;
            end
        end else if (!is_mem) begin
            // Word I/O has no zero-wait form.
            counts.cmd = cfg.wait_state_field[0] ? `CMD16_IO_WS1 : `CMD16_IO_WS0;
        end else begin
            case (cfg.wait_state_field)
                2'h0: counts.cmd = cfg.zero_wait_select ? `CMD16_MEM_ZERO_WAIT : `CMD16_MEM_WS00;
                2'h1: counts.cmd = `CMD16_MEM_WS01;
                2'h2: counts.cmd = `CMD16_MEM_WS10;
                2'h3: counts.cmd = `CMD16_MEM_WS11;
                default: counts.cmd = `CMD16_MEM_WS11;
            endcase
        end
    end
endmodule

//--- src/pc_card16_cycle_timing_generator.sv
// Sequencer that times 16-bit card memory and I/O cycles in clock counts.
// Functional notes
// - All phase times counted in clock cycles.
// - Counts chosen from the access window settings.
// - Intervals never shorter than legacy reference.
// - Setup: I/O 3, memory 2 or 4.
// - Byte command: 19, 23, zero-wait 7.
// - Word I/O command: 7 or 11.
// - Word memory command: 9/13/17/23, zero-wait 5.
// - Hold: I/O 2, memory 2 or 3.
// - Address stable setup plus two before strobe.
// - Address, attribute stable hold plus one after.
// - I/O strobe low for selected command time.
// - Card WAIT stretches strobe until released.
// - Counts sized for a 30 ns clock.
`timescale 1ns/1ns
`include "card_cycle_params.svh"
module pc_card16_cycle_timing_generator
    import card_cycle_pkg::*;
(
    input wire logic clk,
    input wire logic rst_n,
    input wire logic req_valid,
    input card_req_t req,
    input win_cfg_t win_cfg,
    input wire logic card_wait_n,
    input wire logic [15:0] cdata_i,
    output logic req_ready_q,
    output logic done_q,
    output logic [15:0] rdata_q,
    output logic [25:0] card_addr_q,
    output logic reg_n_q,
    output logic [1:0] ce_n_q,
    output logic oe_n_q,
    output logic we_n_q,
    output logic iord_n_q,
    output logic iowr_n_q,
    output logic [15:0] cdata_o_q,
    output logic cdata_oe_q
);
    // Synchronised card inputs.
    logic wait_n_s;
    logic [15:0] cdata_s;
    // Counts looked up for the request now offered.
    cycle_counts_t tbl_counts;
    // Sequencer state, phase counter, latched counts and request.
    cycle_state_t state_q, state_d;
    logic [4:0] cnt_q, cnt_d;
    cycle_counts_t counts_q, counts_d;
    card_req_t cur_q, cur_d;
    // Registered pin and handshake values, next values.
    logic req_ready_d, done_d, reg_n_d, oe_n_d, we_n_d, iord_n_d, iowr_n_d, cdata_oe_d;
    logic [15:0] rdata_d, cdata_o_d;
    logic [25:0] card_addr_d;
    logic [1:0] ce_n_d;
    // A request is taken only while idle.
    logic accept;
    // The card holds the cycle open.
    logic wait_active;
    // Strobe to drive during the command phase.
    logic strobe_d;

    // WAIT idles high, data lines have no idle level.
    pin_sync #(.W(1), .INIT(1'b1)) u_wait_sync (
        .clk(clk),
        .rst_n(rst_n),
        .d(card_wait_n),
        .q(wait_n_s)
    );

    // Read data is sampled through the same two-flop path.
    pin_sync #(.W(16), .INIT(16'h0000)) u_data_sync (
        .clk(clk),
        .rst_n(rst_n),
        .d(cdata_i),
        .q(cdata_s)
    );

    // Count lookup from the window that the access falls into.
    card_timing_table u_table (
        .cfg(win_cfg),
        .is_mem(req.is_mem),
        .is_16bit(req.is_16bit),
        .counts(tbl_counts)
    );

    assign accept = req_valid && (state_q == ST_IDLE);
    assign wait_active = !wait_n_s;

    // Phase sequencer: setup, command, hold, each a down count of clocks.
    always_comb begin
        state_d = state_q;
        cnt_d = cnt_q;
        counts_d = counts_q;
        cur_d = cur_q;
        done_d = 1'b0;
        case (state_q)
            ST_IDLE: begin
                if (accept) begin
                    // Latch the settings once; later changes do not disturb this cycle.
                    cur_d = req;
                    counts_d = tbl_counts;
                    cnt_d = tbl_counts.setup + `SETUP_EXTRA - 5'h01;
                    state_d = ST_SETUP;
                end
            end
            ST_SETUP: begin
                if (cnt_q == 5'h00) begin
                    cnt_d = counts_q.cmd - 5'h01;
                    state_d = ST_CMD;
                end else begin
                    cnt_d = cnt_q - 5'h01;
                end
            end
            ST_CMD: begin
                if (cnt_q != 5'h00) begin
                    cnt_d = cnt_q - 5'h01;
                end else if (!wait_active) begin
                    // Command time spent and card ready: close the strobe.
                    cnt_d = counts_q.hold + `HOLD_EXTRA - 5'h01;
                    state_d = ST_HOLD;
                end
            end
            ST_HOLD: begin
                if (cnt_q == 5'h00) begin
                    // Next address phase may begin only after this.
                    done_d = 1'b1;
                    state_d = ST_IDLE;
                end else begin
                    cnt_d = cnt_q - 5'h01;
                end
            end
            default: begin
                state_d = ST_IDLE;
                cnt_d = 5'h00;
            end
        endcase
    end

    // Pin values follow the next state so every output is a flop.
    always_comb begin
        strobe_d = (state_d == ST_CMD);
        req_ready_d = (state_d == ST_IDLE);
        card_addr_d = accept ? req.addr : card_addr_q;
        // Attribute select and enables hold through the hold phase.
        reg_n_d = (state_d == ST_IDLE) ? 1'b1 : !(cur_d.attr_space || !cur_d.is_mem);
        ce_n_d = (state_d == ST_IDLE) ? `CE_OFF : (cur_d.is_16bit ? `CE_WORD : `CE_BYTE);
        oe_n_d = !(strobe_d && cur_d.is_mem && !cur_d.is_write);
        we_n_d = !(strobe_d && cur_d.is_mem && cur_d.is_write);
        iord_n_d = !(strobe_d && !cur_d.is_mem && !cur_d.is_write);
        iowr_n_d = !(strobe_d && !cur_d.is_mem && cur_d.is_write);
        // Write data is driven from setup through hold.
        cdata_oe_d = (state_d != ST_IDLE) && cur_d.is_write;
        cdata_o_d = accept ? req.wdata : cdata_o_q;
        // Read data is taken in the first hold cycle.
        rdata_d = rdata_q;
        if ((state_q == ST_HOLD) && (cnt_q == counts_q.hold) && !cur_q.is_write) begin
            rdata_d = cdata_s;
        end
    end

    // State and pin registers.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            state_q <= ST_IDLE;
            cnt_q <= 5'h00;
            counts_q <= '0;
            cur_q <= '0;
            req_ready_q <= 1'b1;
            done_q <= 1'b0;
            rdata_q <= 16'h0000;
            card_addr_q <= 26'h0000000;
            reg_n_q <= 1'b1;
            ce_n_q <= `CE_OFF;
            oe_n_q <= 1'b1;
            we_n_q <= 1'b1;
            iord_n_q <= 1'b1;
            iowr_n_q <= 1'b1;
            cdata_o_q <= 16'h0000;
            cdata_oe_q <= 1'b0;
        end else begin
            state_q <= state_d;
            cnt_q <= cnt_d;
            counts_q <= counts_d;
            cur_q <= cur_d;
            req_ready_q <= req_ready_d;
            done_q <= done_d;
            rdata_q <= rdata_d;
            card_addr_q <= card_addr_d;
            reg_n_q <= reg_n_d;
            ce_n_q <= ce_n_d;
            oe_n_q <= oe_n_d;
            we_n_q <= we_n_d;
            iord_n_q <= iord_n_d;
            iowr_n_q <= iowr_n_d;
            cdata_o_q <= cdata_o_d;
            cdata_oe_q <= cdata_oe_d;
        end
    end

    // Checking helpers: cycles spent in the current phase.
    logic [5:0] phase_len_q;
    logic any_strobe;
    assign any_strobe = !(oe_n_q && we_n_q && iord_n_q && iowr_n_q);

    // Counts from zero at each phase entry.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            phase_len_q <= 6'h00;
        end else if (state_d != state_q) begin
            phase_len_q <= 6'h00;
        end else if (phase_len_q != 6'h3F) begin
            phase_len_q <= phase_len_q + 6'h01;
        end
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);

    // Steps of one cycle.
    sequence seq_take;
        accept;
    endsequence
    sequence seq_setup_end;
        (state_q == ST_SETUP) && (state_d == ST_CMD);
    endsequence
    sequence seq_hold_end;
        (state_q == ST_HOLD) && (state_d == ST_IDLE);
    endsequence

    setup_plus_two_a: assert property (seq_setup_end |->
        (phase_len_q == {1'b0, counts_q.setup} + 6'h01)) else $error("setup phase length wrong");
    hold_plus_one_a: assert property (seq_hold_end |->
        (phase_len_q == {1'b0, counts_q.hold})) else $error("hold phase length wrong");
    cmd_min_len_a: assert property ((state_q == ST_CMD) && (state_d == ST_HOLD) |->
        (phase_len_q + 6'h01 >= {1'b0, counts_q.cmd})) else $error("command too short");
    wait_stretch_a: assert property ((state_q == ST_CMD) && wait_active |=>
        (state_q == ST_CMD) && any_strobe) else $error("strobe ended under WAIT");
    addr_stable_a: assert property ((state_q != ST_IDLE) && ($past(state_q) != ST_IDLE) |->
        $stable(card_addr_q) && $stable(reg_n_q)) else $error("address moved in cycle");
    take_latch_a: assert property (seq_take |=>
        (state_q == ST_SETUP) && (card_addr_q == $past(req.addr)) && (counts_q == $past(tbl_counts)))
        else $error("request not latched");
    mem_setup_sel_a: assert property (seq_take and req.is_mem |=>
        counts_q.setup == ($past(win_cfg.wait_state_field[1]) ? `SETUP_MEM_WS1_HI : `SETUP_MEM_WS1_LO))
        else $error("memory setup count wrong");
    byte_cmd_sel_a: assert property (seq_take and
        (!req.is_16bit && req.is_mem && (win_cfg.wait_state_field != 2'h0))
        |=> counts_q.cmd == `CMD8_WAIT) else $error("byte wait count wrong");
    word_mem_sel_a: assert property (seq_take and
        (req.is_16bit && req.is_mem && (win_cfg.wait_state_field == 2'h3))
        |=> counts_q.cmd == `CMD16_MEM_WS11) else $error("word memory count wrong");
    word_io_sel_a: assert property (seq_take and
        (req.is_16bit && !req.is_mem && !win_cfg.wait_state_field[0])
        |=> counts_q.cmd == `CMD16_IO_WS0) else $error("word io count wrong");
    floor_cmd_a: assert property ((state_q != ST_IDLE) |->
        counts_q.cmd >= `CMD16_MEM_ZERO_WAIT) else $error("command below floor");
    one_strobe_a: assert property (any_strobe |->
        $onehot({!oe_n_q, !we_n_q, !iord_n_q, !iowr_n_q})) else $error("two strobes at once");
    no_overlap_a: assert property (seq_hold_end |=>
        (state_q == ST_IDLE) && done_q ##1 !done_q) else $error("cycle overlap");

    // The command phase hands over to hold; the strobe rises at this step.
    sequence seq_cmd_end;
        (state_q == ST_CMD) && (state_d == ST_HOLD);
    endsequence

    // I/O setup does not depend on the wait code.
    io_setup_sel_a: assert property (seq_take and !req.is_mem |=>
        counts_q.setup == `SETUP_IO) else $error("io setup count wrong");

    // Memory hold follows the upper wait bit, like memory setup.
    mem_hold_sel_a: assert property (seq_take and req.is_mem |=>
        counts_q.hold == ($past(win_cfg.wait_state_field[1]) ? `HOLD_MEM_WS1_HI : `HOLD_MEM_WS1_LO))
        else $error("memory hold count wrong");

    // I/O hold is one fixed count.
    io_hold_sel_a: assert property (seq_take and !req.is_mem |=>
        counts_q.hold == `HOLD_IO) else $error("io hold count wrong");

    // Byte zero-wait applies to both spaces when no wait code is set.
    byte_zero_wait_a: assert property (seq_take and
        (!req.is_16bit && win_cfg.zero_wait_select && (win_cfg.wait_state_field == 2'h0))
        |=> counts_q.cmd == `CMD8_ZERO_WAIT) else $error("byte zero-wait count wrong");

    // Word memory zero-wait is the shortest cycle the block can make.
    word_zero_wait_a: assert property (seq_take and
        (req.is_16bit && req.is_mem && win_cfg.zero_wait_select && (win_cfg.wait_state_field == 2'h0))
        |=> counts_q.cmd == `CMD16_MEM_ZERO_WAIT) else $error("word zero-wait count wrong");

    // Word I/O with its wait bit set takes the longer count.
    word_io_wait_a: assert property (seq_take and
        (req.is_16bit && !req.is_mem && win_cfg.wait_state_field[0])
        |=> counts_q.cmd == `CMD16_IO_WS1) else $error("word io wait count wrong");

    // A strobe is low in exactly the command phase.
    strobe_phase_a: assert property (any_strobe == (state_q == ST_CMD))
        else $error("strobe outside command phase");

    // The strobe has risen once hold begins.
    strobe_rise_a: assert property (seq_cmd_end |=> !any_strobe)
        else $error("strobe still low in hold");

    // The command phase never closes while the card holds its wait pin low.
    cmd_release_a: assert property (seq_cmd_end |-> !wait_active)
        else $error("command closed under wait");

    // Ready is shown exactly while the sequencer idles.
    ready_idle_a: assert property (req_ready_q == (state_q == ST_IDLE))
        else $error("ready flag out of step");

    // When done pulses, the card side is already released.
    done_idle_a: assert property (done_q |-> req_ready_q && (ce_n_q == `CE_OFF) && reg_n_q)
        else $error("card still selected at done");
endmodule

//--- tb/card_model.sv
// Behavioural 16-bit card that answers reads and can stretch a cycle with its wait pin.
`timescale 1ns/1ns
module card_model (
    input wire logic clk,
    input wire logic oe_n,
    input wire logic iord_n,
    input wire logic we_n,
    input wire logic iowr_n,
    input wire logic [7:0] wait_len,
    input wire logic [15:0] rd_word,
    output logic card_wait_n,
    output logic [15:0] cdata_i
);
    // Cycles the current strobe has been low, and wait cycles still to give.
    int low_cnt;
    int wait_left;
    // The wait pin idles high, as its pull-up would leave it.
    initial begin
        card_wait_n = 1'b1;
        cdata_i = 16'h0000;
        low_cnt = 0;
        wait_left = 0;
    end
    // Pins change off the falling edge; released data toggles so a stale word never matches.
    always @(negedge clk) begin
        if (!(oe_n && iord_n && we_n && iowr_n)) begin
            low_cnt = low_cnt + 1;
        end else begin
            low_cnt = 0;
        end
        // Wait is pulled low in the second strobe cycle and held for wait_len cycles.
        if (low_cnt == 2) wait_left = wait_len;
        card_wait_n <= (wait_left == 0);
        if (wait_left > 0) wait_left = wait_left - 1;
        cdata_i <= (!oe_n || !iord_n) ? rd_word : ~cdata_i;
    end
endmodule

//--- tb/tb_top.sv
// Self-checking bench for the card cycle timing generator.
`timescale 1ns/1ns
module tb_top
    import card_cycle_pkg::*;
;
    // Design ports and bench state.
    logic clk, rst_n, req_valid, card_wait_n, req_ready_q, done_q, reg_n_q;
    logic oe_n_q, we_n_q, iord_n_q, iowr_n_q, cdata_oe_q;
    card_req_t req;
    win_cfg_t win_cfg;
    logic [15:0] cdata_i, rdata_q, cdata_o_q, rd_word;
    logic [25:0] card_addr_q;
    logic [1:0] ce_n_q;
    logic [7:0] wait_len;
    int errors, compares;

    pc_card16_cycle_timing_generator dut (.clk(clk), .rst_n(rst_n), .req_valid(req_valid), .req(req),
        .win_cfg(win_cfg), .card_wait_n(card_wait_n), .cdata_i(cdata_i), .req_ready_q(req_ready_q),
        .done_q(done_q), .rdata_q(rdata_q), .card_addr_q(card_addr_q), .reg_n_q(reg_n_q), .ce_n_q(ce_n_q),
        .oe_n_q(oe_n_q), .we_n_q(we_n_q), .iord_n_q(iord_n_q), .iowr_n_q(iowr_n_q), .cdata_o_q(cdata_o_q),
        .cdata_oe_q(cdata_oe_q));

    card_model card (.clk(clk), .oe_n(oe_n_q), .iord_n(iord_n_q), .we_n(we_n_q), .iowr_n(iowr_n_q),
        .wait_len(wait_len), .rd_word(rd_word), .card_wait_n(card_wait_n), .cdata_i(cdata_i));

    // Free-running 25 MHz clock.
    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end

    // Prints the verdict and ends the run.
    task automatic summarize();
        if (errors == 0 && compares > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    // Compares one value exactly.
    task automatic check_eq(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp) begin
            errors++;
            $display("unexpected at %0t: got %0h expected %0h", $time, got, exp);
        end
    endtask

    // Compares a count against an inclusive window.
    task automatic check_range(input logic [31:0] got, input logic [31:0] lo, input logic [31:0] hi);
        compares++;
        if (!(got >= lo && got <= hi)) begin
            errors++;
            $display("unexpected at %0t: got %0h expected %0h..%0h", $time, got, lo, hi);
        end
    endtask

    // Holds reset 16 cycles and checks the idle pin state during and after it.
    task automatic test_reset();
        @(negedge clk);
        rst_n = 1'b0;
        repeat (16) @(negedge clk);
        check_eq({req_ready_q, done_q, oe_n_q, we_n_q, iord_n_q, iowr_n_q, reg_n_q, ce_n_q, cdata_oe_q}, 10'h2FE);
        check_eq(card_addr_q, 26'h0000000);
        rst_n = 1'b1;
        @(negedge clk);
        check_eq({req_ready_q, done_q, oe_n_q, we_n_q, iord_n_q, iowr_n_q, reg_n_q, ce_n_q, cdata_oe_q}, 10'h2FE);
    endtask

    // Runs one card cycle, entered at a falling edge, and judges its phases against the count tables.
    task automatic run_cycle(input logic mem, input logic wr, input logic w16, input logic [1:0] ws,
                             input logic zws, input logic refuse, input logic [7:0] wl);
        int s, c, h, k, lo_first, lows;
        logic bad, strb;
        logic [25:0] a;
        s = !mem ? 3 : (ws[1] ? 4 : 2);
        h = !mem ? 2 : (ws[1] ? 3 : 2);
        if (zws && ws == 2'h0 && !(w16 && !mem)) c = w16 ? 5 : 7;
        else if (!w16) c = (mem ? ws != 2'h0 : ws[0]) ? 23 : 19;
        else if (!mem) c = ws[0] ? 11 : 7;
        else c = 9 + 4 * ws + (ws == 2'h3 ? 2 : 0);
        a = {8'h00, ws, zws, mem, wr, w16, 12'hC35};
        rd_word = {ws, zws, 13'h1E6A};
        wait_len = wl;
        req = '{is_mem: mem, is_write: wr, is_16bit: w16, attr_space: ws[0], addr: a, wdata: ~rd_word};
        win_cfg = '{timing_set_select: 2'h1, wait_state_field: ws, zero_wait_select: zws};
        req_valid = 1'b1;
        k = 0;
        while (req_ready_q !== 1'b1 && k < 100) begin
            @(negedge clk);
            k++;
        end
        @(negedge clk);
        // A second offer while busy carries another address and must be ignored.
        req.addr = ~a;
        req_valid = refuse;
        bad = 1'b0;
        lows = 0;
        lo_first = 0;
        k = 1;
        while (done_q !== 1'b1 && k < 200) begin
            strb = mem ? (wr ? we_n_q : oe_n_q) : (wr ? iowr_n_q : iord_n_q);
            if (strb === 1'b0) begin
                if (lows == 0) lo_first = k;
                lows++;
            end
            if (lo_first == k) req_valid = 1'b0;
            if (card_addr_q !== a || ce_n_q !== (w16 ? 2'h0 : 2'h2) || reg_n_q !== !(ws[0] || !mem)) bad = 1'b1;
            if ($countones(~{oe_n_q, we_n_q, iord_n_q, iowr_n_q}) != ((strb === 1'b0) ? 1 : 0)) bad = 1'b1;
            if (cdata_oe_q !== wr || (wr && strb === 1'b0 && cdata_o_q !== ~rd_word)) bad = 1'b1;
            @(negedge clk);
            k++;
        end
        check_eq(lo_first, s + 3);
        if (wl == 8'h00) check_eq(lows, c);
        else check_range(lows, wl + 2, wl + 6);
        check_eq(k, s + lows + h + 4);
        check_eq(bad, 1'b0);
        check_eq(req_ready_q, 1'b1);
        if (!wr) check_eq(w16 ? rdata_q : rdata_q[7:0], w16 ? rd_word : rd_word[7:0]);
    endtask

    // Byte cycles over every wait code, both spaces, reads and writes, and the zero-wait option.
    task automatic test_byte();
        for (int i = 0; i < 4; i++) begin
            run_cycle(1'b1, i[0], 1'b0, i[1:0], 1'b0, 1'b0, 8'h00);
            run_cycle(1'b0, i[0], 1'b0, i[1:0], 1'b0, 1'b0, 8'h00);
        end
        run_cycle(1'b1, 1'b0, 1'b0, 2'h0, 1'b1, 1'b0, 8'h00);
        run_cycle(1'b0, 1'b1, 1'b0, 2'h0, 1'b1, 1'b0, 8'h00);
    endtask

    // Word cycles back to back; zero-wait must not shorten word I/O.
    task automatic test_word();
        for (int i = 0; i < 4; i++) begin
            run_cycle(1'b1, i[0], 1'b1, i[1:0], 1'b0, 1'b0, 8'h00);
        end
        run_cycle(1'b1, 1'b1, 1'b1, 2'h0, 1'b1, 1'b0, 8'h00);
        run_cycle(1'b0, 1'b0, 1'b1, 2'h0, 1'b0, 1'b0, 8'h00);
        run_cycle(1'b0, 1'b1, 1'b1, 2'h1, 1'b0, 1'b0, 8'h00);
        run_cycle(1'b0, 1'b0, 1'b1, 2'h0, 1'b1, 1'b0, 8'h00);
    endtask

    // The card stretches a memory read and an I/O read past the programmed count.
    task automatic test_wait();
        run_cycle(1'b1, 1'b0, 1'b1, 2'h0, 1'b0, 1'b0, 8'h14);
        run_cycle(1'b0, 1'b0, 1'b1, 2'h1, 1'b0, 1'b0, 8'h14);
    endtask

    // Offers made while busy are dropped and the running cycle is untouched.
    task automatic test_refuse();
        run_cycle(1'b1, 1'b1, 1'b1, 2'h3, 1'b0, 1'b1, 8'h00);
        run_cycle(1'b0, 1'b0, 1'b0, 2'h1, 1'b0, 1'b1, 8'h00);
    endtask

    // Cuts a hang short well beyond the expected run of about 650 cycles.
    initial begin
        #(4000 * 40);
        errors++;
        summarize();
    end

    // Main sequence.
    initial begin
        errors = 0;
        compares = 0;
        rst_n = 1'b0;
        req_valid = 1'b0;
        req = '0;
        win_cfg = '0;
        rd_word = 16'h0000;
        wait_len = 8'h00;
        test_reset();
        test_byte();
        test_word();
        test_wait();
        test_refuse();
        test_reset();
        run_cycle(1'b1, 1'b0, 1'b1, 2'h2, 1'b0, 1'b0, 8'h00);
        summarize();
    end
endmodule
